// ==== verilog/orpc_regs.vh ====
// Register map, field positions, reset values and timing counts of the protection controller
`ifndef ORPC_REGS_VH
`define ORPC_REGS_VH

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define ORPC_OFS_CMD 6'h00
`define ORPC_OFS_STATUS 6'h04
`define ORPC_OFS_CONFIG 6'h08
`define ORPC_OFS_LOCK 6'h0c
`define ORPC_OFS_PW_LO 6'h10
`define ORPC_OFS_PW_HI 6'h14
`define ORPC_OFS_DATA_LO 6'h18
`define ORPC_OFS_DATA_HI 6'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ORPC_ST_WIP 0
`define ORPC_ST_PERR 5
`define ORPC_CFG_PERM 0
`define ORPC_CFG_LOCKDN 1
`define ORPC_CFG_PASSWD 2
`define ORPC_CFG_BLKDEF 4
`define ORPC_CFG_R3RD 6
`define ORPC_LK_UNLOCK 0
`define ORPC_LK_R3RD 6
`define ORPC_CFG_OTP_MASK 8'h57

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ORPC_CFG_RESET 8'hff
`define ORPC_PW_RESET 64'hffff_ffff_ffff_ffff

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define ORPC_CMD_LOCK 8'ha6
`define ORPC_CMD_UNLOCK 8'hea
`define ORPC_CMD_PROG_CFG 8'h2f
`define ORPC_CMD_PROG_PW 8'he8
`define ORPC_CMD_SOFT_RST 8'h99

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ORPC_CLK_MHZ 25
`define ORPC_PROG_US 700
`define ORPC_PROG_CYC (`ORPC_PROG_US * `ORPC_CLK_MHZ)
`define ORPC_HAMMER_US 100
`define ORPC_HAMMER_CYC (`ORPC_HAMMER_US * `ORPC_CLK_MHZ)
`define ORPC_LINK_BITS 72

`endif

// ==== verilog/orpc_sync.v ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module orpc_sync #(
    parameter WIDTH = 4
) (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] s1;
    reg [WIDTH-1:0] s2;
    reg [WIDTH-1:0] s3;
    integer i;

    // ----------------------------------------------------------------
    // Stages; a change counts only once stage two and three agree
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1 <= {WIDTH{1'b0}};
            s2 <= {WIDTH{1'b0}};
            s3 <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/orpc_top.v ====
// Region protection controller: mode OTP, volatile lock bits, password unlock
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "orpc_regs.vh"
module orpc_top #(
    parameter PROG_CYCLES = `ORPC_PROG_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire hw_rst_pin,
    input wire cs_n_pin,
    input wire sck_pin,
    input wire si_pin,
    output reg nonvol_area_unlock,
    output reg region3_read_enable,
    output reg blk_lock_load,
    output reg blk_lock_protected,
    output reg write_in_progress
);
    localparam integer HAMMER_INT = `ORPC_HAMMER_CYC;
    localparam integer PROG_INT = PROG_CYCLES;
    localparam integer LINK_INT = `ORPC_LINK_BITS;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [7:0] region_protect_config;
    reg [63:0] password;
    reg [63:0] data_op;
    reg program_error_flag;
    reg [15:0] busy_cnt;
    reg [31:0] next_readdata;
    wire [3:0] pins_s;
    wire hw_rst_s;
    wire cs_n_s;
    wire sck_s;
    wire si_s;
    reg hw_rst_d;
    reg cs_n_d;
    reg sck_d;
    reg [71:0] link_shift;
    reg [6:0] link_cnt;
    reg link_pend;
    reg [7:0] link_op;
    reg [63:0] link_pw;
    wire pw_mode;
    wire perm_mode;
    wire mode_chosen;
    wire bus_acc;
    wire bus_cmd;
    wire cmd_go;
    wire [7:0] cmd_code;
    wire [63:0] cmd_pw;
    wire [7:0] cfg_new;
    wire [2:0] mode_zero;
    wire hw_rst_rise;
    wire cs_rise;
    wire sck_rise;
    wire [63:0] data_next;
    wire [63:0] be_mask;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    orpc_sync #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .din({hw_rst_pin, ~cs_n_pin, sck_pin, si_pin}),
        .dout(pins_s)
    );

    assign hw_rst_s = pins_s[3];
    assign cs_n_s = ~pins_s[2]; // Kept inverted so reset level means deselected
    assign sck_s = pins_s[1];
    assign si_s = pins_s[0];

    // Edges of the filtered pins
    assign hw_rst_rise = hw_rst_s & ~hw_rst_d;
    assign cs_rise = cs_n_s & ~cs_n_d;
    assign sck_rise = sck_s & ~sck_d & ~cs_n_s;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Unprogrammed part behaves as lock-down
    assign pw_mode = ~region_protect_config[`ORPC_CFG_PASSWD];
    assign perm_mode = ~region_protect_config[`ORPC_CFG_PERM];
    assign mode_chosen = ~&region_protect_config[2:0];

    // Programming can only clear OTP bits; non-OTP bits stay one
    assign cfg_new = region_protect_config & (data_op[7:0] | ~`ORPC_CFG_OTP_MASK);
    assign mode_zero = ~data_op[2:0];

    // ----------------------------------------------------------------
    // Bus decode; a request is taken on the edge seeing waitrequest low
    // ----------------------------------------------------------------
    assign bus_acc = ~avs_waitrequest & (avs_read | avs_write);
    assign bus_cmd = bus_acc & avs_write & (avs_address == `ORPC_OFS_CMD) & avs_byteenable[0];

    // Bus command wins; a link command waits one slot in its holder
    assign cmd_go = (bus_cmd | link_pend) & ~write_in_progress;
    assign cmd_code = bus_cmd ? avs_writedata[7:0] : link_op;
    assign cmd_pw = bus_cmd ? data_op : link_pw;

    // Byte-lane merge of the operand registers
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}},
                      {8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign data_next = (data_op & ~be_mask) | ({avs_writedata, avs_writedata} & be_mask);

    // ----------------------------------------------------------------
    // Read data mux
    // ----------------------------------------------------------------
    always @* begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            `ORPC_OFS_STATUS: begin
                next_readdata[`ORPC_ST_WIP] = write_in_progress;
                next_readdata[`ORPC_ST_PERR] = program_error_flag;
            end
            `ORPC_OFS_CONFIG: begin
                next_readdata[7:0] = region_protect_config;
            end
            `ORPC_OFS_LOCK: begin
                next_readdata[`ORPC_LK_UNLOCK] = nonvol_area_unlock;
                next_readdata[`ORPC_LK_R3RD] = region3_read_enable;
            end
            // Hidden once password mode is chosen
            `ORPC_OFS_PW_LO: begin
                next_readdata = pw_mode ? 32'h0000_0000 : password[31:0];
            end
            `ORPC_OFS_PW_HI: begin
                next_readdata = pw_mode ? 32'h0000_0000 : password[63:32];
            end
            `ORPC_OFS_DATA_LO: begin
                next_readdata = data_op[31:0];
            end
            `ORPC_OFS_DATA_HI: begin
                next_readdata = data_op[63:32];
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Bus handshake: one wait cycle, then the answer for one cycle
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (ce) begin
            if (avs_waitrequest && (avs_read || avs_write)) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= next_readdata;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial link: opcode then optional 64-bit password, MSB first
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hw_rst_d <= 1'b0;
            cs_n_d <= 1'b1;
            sck_d <= 1'b0;
            link_shift <= 72'h0;
            link_cnt <= 7'h00;
            link_pend <= 1'b0;
            link_op <= 8'h00;
            link_pw <= 64'h0;
        end else if (ce) begin
            hw_rst_d <= hw_rst_s;
            cs_n_d <= cs_n_s;
            sck_d <= sck_s;
            if (sck_rise) begin
                link_shift <= {link_shift[70:0], si_s};
                if (link_cnt != 7'h7f) begin
                    link_cnt <= link_cnt + 7'h01;
                end
            end else if (cs_rise) begin
                link_cnt <= 7'h00;
            end
            // Framing decides the opcode; frames other than 8 or 72 bits are dropped
            if (cs_rise && !hw_rst_s) begin
                if (link_cnt == 7'd8 && link_shift[7:0] == `ORPC_CMD_LOCK) begin
                    link_pend <= 1'b1;
                    link_op <= `ORPC_CMD_LOCK;
                end else if (link_cnt == LINK_INT[6:0]
                             && link_shift[71:64] == `ORPC_CMD_UNLOCK) begin
                    link_pend <= 1'b1;
                    link_op <= `ORPC_CMD_UNLOCK;
                    link_pw <= link_shift[63:0];
                end
            end else if (!bus_cmd || hw_rst_s) begin
                // Taken or dropped once its slot comes
                link_pend <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Protection core
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            region_protect_config <= `ORPC_CFG_RESET;
            password <= `ORPC_PW_RESET;
            data_op <= 64'h0;
            program_error_flag <= 1'b0;
            busy_cnt <= 16'h0000;
            write_in_progress <= 1'b0;
            nonvol_area_unlock <= 1'b1;
            region3_read_enable <= 1'b1;
            blk_lock_load <= 1'b1;
            blk_lock_protected <= 1'b1;
        end else if (ce) begin
            blk_lock_load <= 1'b0;
            // Operand registers
            if (bus_acc && avs_write && avs_address == `ORPC_OFS_DATA_LO) begin
                data_op[31:0] <= data_next[31:0];
            end
            if (bus_acc && avs_write && avs_address == `ORPC_OFS_DATA_HI) begin
                data_op[63:32] <= data_next[63:32];
            end
            // Busy countdown
            if (busy_cnt != 16'h0000) begin
                busy_cnt <= busy_cnt - 16'h0001;
                if (busy_cnt == 16'h0001) begin
                    write_in_progress <= 1'b0;
                end
            end
            // Error clear by writing one; a new error below wins
            if (bus_acc && avs_write && avs_address == `ORPC_OFS_STATUS
                && avs_byteenable[0] && avs_writedata[`ORPC_ST_PERR]) begin
                program_error_flag <= 1'b0;
            end
            if (hw_rst_rise) begin
                // Hardware reset: volatile bits by mode, OTP untouched
                busy_cnt <= 16'h0000;
                write_in_progress <= 1'b0;
                program_error_flag <= 1'b0;
                nonvol_area_unlock <= ~pw_mode & ~perm_mode;
                region3_read_enable <= pw_mode ? region_protect_config[`ORPC_CFG_R3RD]
                                               : 1'b1;
                blk_lock_load <= 1'b1;
                blk_lock_protected <= region_protect_config[`ORPC_CFG_BLKDEF];
            end else if (cmd_go) begin
                case (cmd_code)
                    `ORPC_CMD_LOCK: begin
                        nonvol_area_unlock <= 1'b0;
                    end
                    `ORPC_CMD_UNLOCK: begin
                        // Only password mode lets this command raise the unlock bit
                        if (pw_mode) begin
                            write_in_progress <= 1'b1;
                            if (cmd_pw == password) begin
                                nonvol_area_unlock <= 1'b1;
                                busy_cnt <= 16'h0001;
                            end else begin
                                program_error_flag <= 1'b1;
                                busy_cnt <= HAMMER_INT[15:0];
                            end
                        end
                    end
                    `ORPC_CMD_PROG_CFG: begin
                        // Mode bits cannot be programmed twice, nor two at once
                        if (mode_chosen || (mode_zero[0] & mode_zero[1])
                            || (mode_zero[2] & (mode_zero[0] | mode_zero[1]))) begin
                            program_error_flag <= 1'b1;
                        end else begin
                            region_protect_config <= cfg_new;
                            write_in_progress <= 1'b1;
                            busy_cnt <= PROG_INT[15:0];
                        end
                    end
                    `ORPC_CMD_PROG_PW: begin
                        // Ones never restore a cleared cell, and no error
                        if (!pw_mode) begin
                            password <= password & cmd_pw;
                            write_in_progress <= 1'b1;
                            busy_cnt <= PROG_INT[15:0];
                        end
                    end
                    `ORPC_CMD_SOFT_RST: begin
                        // Unlock bit survives a software reset
                        region3_read_enable <= pw_mode ? region_protect_config[`ORPC_CFG_R3RD]
                                                       : 1'b1;
                        blk_lock_load <= 1'b1;
                        blk_lock_protected <= region_protect_config[`ORPC_CFG_BLKDEF];
                    end
                    default: begin
                        program_error_flag <= program_error_flag;
                    end
                endcase
            end
            // Permanent mode pins both bits regardless of commands
            if (perm_mode) begin
                nonvol_area_unlock <= 1'b0;
                region3_read_enable <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/orpc_top_assertions.sv ====
// Port checks for the region protection controller
`timescale 1ns/100ps
`default_nettype none
`include "orpc_regs.vh"
module orpc_top_assertions #(
    parameter PROG_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic hw_rst_pin,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic nonvol_area_unlock,
    input wire logic region3_read_enable,
    input wire logic blk_lock_load,
    input wire logic blk_lock_protected,
    input wire logic write_in_progress
);
    // ----
    // Helpers
    // ----
    int wip_cnt;
    int since_wip;
    // Busy run length, and cycles since busy was last seen
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wip_cnt <= 0;
            since_wip <= 9;
        end else begin
            wip_cnt <= write_in_progress ? wip_cnt + 1 : 0;
            since_wip <= write_in_progress ? 0 : (since_wip < 9 ? since_wip + 1 : 9);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----
    // Properties
    // ----
    AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no bus answer");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_LOCK_CLEAR: assert property (
        avs_write && !avs_waitrequest && !write_in_progress && !hw_rst_pin
        && avs_address == `ORPC_OFS_CMD && avs_byteenable[0]
        && avs_writedata[7:0] == `ORPC_CMD_LOCK |-> ##[1:3] !nonvol_area_unlock)
        else $error("lock engage left unlock set");
    AST_HW_LOAD: assert property (
        $rose(hw_rst_pin) |-> ##[1:10] blk_lock_load)
        else $error("no preset after hardware reset");
    AST_LOAD_PULSE: assert property (
        blk_lock_load |=> !blk_lock_load)
        else $error("preset pulse too long");
    AST_UNLOCK_CAUSE: assert property (
        $rose(nonvol_area_unlock) |-> blk_lock_load || $past(blk_lock_load)
        || write_in_progress || since_wip <= 2)
        else $error("unlock rose without cause");
    AST_FAIL_LOCKED: assert property (
        write_in_progress && !nonvol_area_unlock ##1 write_in_progress |-> !nonvol_area_unlock)
        else $error("unlock rose while busy");
    AST_R3_RELOAD: assert property (
        $changed(region3_read_enable) |-> ($past(blk_lock_load) or ##[0:1] blk_lock_load))
        else $error("read bit changed outside reload");
    AST_BUSY_SPAN: assert property (
        $fell(write_in_progress) && !hw_rst_pin |-> wip_cnt <= 2
        || (wip_cnt >= PROG_CYCLES - 2 && wip_cnt <= PROG_CYCLES + 2)
        || (wip_cnt >= 2000 && wip_cnt <= 3000))
        else $error("busy span off");
    COV_UNLOCK: cover property ($rose(nonvol_area_unlock) && !blk_lock_load);
    COV_HAMMER: cover property ($fell(write_in_progress) && wip_cnt > 1000);
    COV_UNPROT: cover property (blk_lock_load && !blk_lock_protected);
endmodule
`default_nettype wire

// ==== verification/orpc_link_host.sv ====
// Host side of the serial link: sends whole frames
`timescale 1ns/100ps
`default_nettype none
module orpc_link_host (
    output logic cs_n_pin,
    output logic sck_pin,
    output logic si_pin
);
    // Deselected, clock parked low
    initial begin
        cs_n_pin = 1'h1;
        sck_pin = 1'h0;
        si_pin = 1'h0;
    end
    // MSB first at 320 ns per bit; clock stands still between frames
    task automatic send(input int nbits, input logic [71:0] frame);
        int i;
        #37;
        cs_n_pin = 1'h0;
        for (i = nbits - 1; i >= 0; i--) begin
            si_pin = frame[i];
            #160 sck_pin = 1'h1;
            #160 sck_pin = 1'h0;
        end
        #160 cs_n_pin = 1'h1;
        // Released data line is not held, so nothing may lean on it
        si_pin = ~si_pin;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the region protection controller
`timescale 1ns/100ps
`default_nettype none
`include "orpc_regs.vh"
module tb_top;
    localparam logic [63:0] PW = 64'h0abc_def0_1234_5678;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic hw_rst_pin = 1'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cs_n_pin;
    logic sck_pin;
    logic si_pin;
    logic nonvol_area_unlock;
    logic region3_read_enable;
    logic blk_lock_load;
    logic blk_lock_protected;
    logic write_in_progress;
    logic [31:0] rd;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_load = 0;
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    // Preset pulses outside power-on reset
    always @(posedge ref_clk) begin
        if (!rst && blk_lock_load === 1'h1) n_load++;
    end
    orpc_top #(.PROG_CYCLES(20)) uut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hw_rst_pin(hw_rst_pin), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .si_pin(si_pin), .nonvol_area_unlock(nonvol_area_unlock),
        .region3_read_enable(region3_read_enable), .blk_lock_load(blk_lock_load),
        .blk_lock_protected(blk_lock_protected), .write_in_progress(write_in_progress));
    orpc_link_host u_host (.cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin));
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pchk(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // Request holds until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int i;
        logic w;
        i = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge ref_clk);
            w = avs_waitrequest;
            rd = avs_readdata;
            i++;
        end while (w !== 1'h0 && i < 50);
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (w !== 1'h0) chk("bus", 32'h0, 32'h1);
    endtask
    task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] m, e);
        bus(1'h0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic cmd(input logic [7:0] code, input logic [7:0] arg);
        bus(1'h1, `ORPC_OFS_CMD, {16'h0, arg, code});
    endtask
    task automatic opnd(input logic [63:0] v);
        bus(1'h1, `ORPC_OFS_DATA_LO, v[31:0]);
        bus(1'h1, `ORPC_OFS_DATA_HI, v[63:32]);
    endtask
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // Host polls busy before the next command
    task automatic idle();
        int i;
        for (i = 0; i < 2000; i++) begin
            bus(1'h0, `ORPC_OFS_STATUS, 32'h0);
            if (rd[`ORPC_ST_WIP] === 1'h0) break;
        end
        chk("busy_end", 32'h0, {31'h0, rd[`ORPC_ST_WIP]});
    endtask
    task automatic hwrst();
        @(posedge ref_clk);
        hw_rst_pin <= 1'h1;
        repeat (10) @(posedge ref_clk);
        hw_rst_pin <= 1'h0;
        settle();
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_fresh();
        bus(1'h1, `ORPC_OFS_CONFIG, 32'h0);
        rdchk("config", `ORPC_OFS_CONFIG, 32'hff, 32'hff);
        rdchk("lock", `ORPC_OFS_LOCK, 32'h41, 32'h41);
        rdchk("pw_lo", `ORPC_OFS_PW_LO, 32'hffff_ffff, 32'hffff_ffff);
        rdchk("hole", 6'h20, 32'hffff_ffff, 32'h0);
        pchk("blk_prot", 1'h1, blk_lock_protected);
    endtask
    task automatic t_pwprog();
        opnd(PW | 64'hf000_0000_0000_0000);
        cmd(`ORPC_CMD_PROG_PW, 8'h00);
        settle();
        pchk("pw_busy", 1'h1, write_in_progress);
        idle();
        opnd(64'h0fff_ffff_ffff_ffff);
        cmd(`ORPC_CMD_PROG_PW, 8'h00);
        idle();
        rdchk("pw_lo", `ORPC_OFS_PW_LO, 32'hffff_ffff, PW[31:0]);
        rdchk("pw_hi", `ORPC_OFS_PW_HI, 32'hffff_ffff, PW[63:32]);
        rdchk("perr", `ORPC_OFS_STATUS, 32'h20, 32'h0);
    endtask
    task automatic t_lockdown();
        int base;
        cmd(`ORPC_CMD_LOCK, 8'h00);
        settle();
        pchk("lock_cmd", 1'h0, nonvol_area_unlock);
        base = n_load;
        cmd(`ORPC_CMD_SOFT_RST, 8'h00);
        settle();
        pchk("soft_keep", 1'h0, nonvol_area_unlock);
        chk("soft_load", 32'h1, 32'(n_load - base));
        hwrst();
        pchk("hw_set", 1'h1, nonvol_area_unlock);
        u_host.send(8, 72'ha6);
        settle();
        pchk("link_lock", 1'h0, nonvol_area_unlock);
        hwrst();
    endtask
    // Password mode together with read protection and unprotected default
    task automatic t_pwmode();
        opnd(64'hffff_ffff_ffff_ffab);
        cmd(`ORPC_CMD_PROG_CFG, 8'hab);
        settle();
        pchk("cfg_busy", 1'h1, write_in_progress);
        idle();
        rdchk("config", `ORPC_OFS_CONFIG, 32'h57, 32'h03);
        rdchk("pw_hide", `ORPC_OFS_PW_LO, 32'hffff_ffff, 32'h0);
        opnd(64'h0);
        cmd(`ORPC_CMD_PROG_PW, 8'h00);
        idle();
        opnd(64'hffff_ffff_ffff_fffe);
        cmd(`ORPC_CMD_PROG_CFG, 8'hfe);
        idle();
        rdchk("perr", `ORPC_OFS_STATUS, 32'h20, 32'h20);
        rdchk("config2", `ORPC_OFS_CONFIG, 32'h57, 32'h03);
        bus(1'h1, `ORPC_OFS_STATUS, 32'h20);
        hwrst();
        pchk("pw_locked", 1'h0, nonvol_area_unlock);
        pchk("r3_read", 1'h0, region3_read_enable);
        pchk("blk_prot", 1'h0, blk_lock_protected);
    endtask
    // One wrong bit, then the right password, then relock and unlock by link
    task automatic t_unlock();
        u_host.send(72, {8'hea, PW ^ 64'h1});
        settle();
        pchk("bad_busy", 1'h1, write_in_progress);
        pchk("bad_lock", 1'h0, nonvol_area_unlock);
        repeat (1900) @(posedge ref_clk);
        @(negedge ref_clk);
        pchk("hammer", 1'h1, write_in_progress);
        idle();
        rdchk("perr", `ORPC_OFS_STATUS, 32'h20, 32'h20);
        bus(1'h1, `ORPC_OFS_STATUS, 32'h20);
        opnd(PW);
        cmd(`ORPC_CMD_UNLOCK, 8'h00);
        rdchk("fast", `ORPC_OFS_STATUS, 32'h21, 32'h0);
        pchk("good", 1'h1, nonvol_area_unlock);
        u_host.send(8, 72'ha6);
        settle();
        pchk("relock", 1'h0, nonvol_area_unlock);
        u_host.send(72, {8'hea, PW});
        settle();
        pchk("link_ok", 1'h1, nonvol_area_unlock);
    endtask
    task automatic t_perm();
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        opnd(64'hffff_ffff_ffff_fffe);
        cmd(`ORPC_CMD_PROG_CFG, 8'hfe);
        idle();
        hwrst();
        rdchk("perm", `ORPC_OFS_LOCK, 32'h41, 32'h40);
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        t_fresh();
        t_pwprog();
        t_lockdown();
        t_pwmode();
        t_unlock();
        t_perm();
        tally_and_finish();
    end
    // Hang guard, far past the expected run length
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind orpc_top orpc_top_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hw_rst_pin(hw_rst_pin),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
    .nonvol_area_unlock(nonvol_area_unlock), .region3_read_enable(region3_read_enable),
    .blk_lock_load(blk_lock_load), .blk_lock_protected(blk_lock_protected),
    .write_in_progress(write_in_progress));
`default_nettype wire
